// [include/spi_bridge_pkg.sv]
package spi_bridge_pkg;

  localparam int unsigned SYS_CLK_HZ = 25_000_000;

  // Word-aligned register byte offsets
  localparam logic [7:0] OFS_SERIAL_CTRL0 = 8'h00;
  localparam logic [7:0] OFS_PIN_REMAP0   = 8'h04;
  localparam logic [7:0] OFS_SPI_DATA     = 8'h08;
  localparam logic [7:0] OFS_LINK_CTRL    = 8'h0c;
  localparam logic [7:0] OFS_STATUS       = 8'h10;

  // Serial mode field codes
  localparam logic [2:0] MODE_DIV4     = 3'h0;
  localparam logic [2:0] MODE_DIV16    = 3'h1;
  localparam logic [2:0] MODE_DIV64    = 3'h2;
  localparam logic [2:0] MODE_TIMEBASE = 3'h3;
  localparam logic [2:0] MODE_TIMER0   = 3'h4;

  // Clock-out rate codes
  localparam logic [1:0] PCK_SYS    = 2'h0;
  localparam logic [1:0] PCK_DIV4   = 2'h1;
  localparam logic [1:0] PCK_DIV8   = 2'h2;
  localparam logic [1:0] PCK_TIMER0 = 2'h3;

  // Half-period counts of the SPI clock in system clocks, clock-out counter limits and last SPI edge index
  localparam logic [5:0] HALF_DIV4  = 6'h02;
  localparam logic [5:0] HALF_DIV16 = 6'h08;
  localparam logic [5:0] HALF_DIV64 = 6'h20;
  localparam logic [2:0] PCK_LIM4   = 3'h3;
  localparam logic [2:0] PCK_LIM8   = 3'h7;
  localparam logic [4:0] EDGES_LAST = 5'h0f;

  localparam logic [7:0] SERIAL_CTRL0_RESET = 8'h00;
  localparam logic [2:0] PIN_REMAP0_RESET   = 3'h0;
  localparam logic [1:0] LINK_CTRL_RESET    = 2'h1;

  // Status register bit positions
  localparam int unsigned ST_BUSY_BIT = 0;
  localparam int unsigned ST_ERR_BIT  = 1;
  localparam int unsigned ST_INT_BIT  = 2;
  localparam int unsigned ST_SCK_BIT  = 3;

  typedef struct packed {
    logic [2:0] spi_mode_select;
    logic       clock_out_enable;
    logic [1:0] clock_out_rate_select;
    logic       serial_module_enable;
    logic       spare;
  } serial_ctrl_type;

  typedef struct packed {
    logic remap_select_high;
    logic remap_select_low;
    logic clock_out_remap_select;
  } pin_remap_type;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_XFER = 2'b10
  } spi_state_type;

endpackage

// [verilog/spi_uart_bridge.sv]
`timescale 1ns/1ps

// Summary of operation
// - The serial module acts as SPI master toward the companion UART's SPI slave port.
// - The pin-remap register routes clock-out and interrupt lines through its three low remap bits.
// - Mode codes 000, 001 and 010 give an SPI clock of system clock over 4, 16 and 64.
// - Mode 011 clocks SPI from the timebase clock and 100 at half the timer-0 period match rate.
// - Clock-out codes 00, 01 and 10 give system clock, over 4 and over 8.
// - Clock-out code 11 gives half the timer-0 period match rate.
// - The clock-out enable bit gates the peripheral clock that feeds the UART baud generator.
module spi_uart_bridge
  import spi_bridge_pkg::*;
(
  input  wire logic        i_sys_clk,
  input  wire logic        i_sys_rst,
  input  wire logic        i_clk_en,
  input  wire logic        i_wb_cyc,
  input  wire logic        i_wb_stb,
  input  wire logic        i_wb_we,
  input  wire logic [7:0]  i_wb_adr,
  input  wire logic [31:0] i_wb_dat,
  input  wire logic [3:0]  i_wb_sel,
  output logic      [31:0] o_wb_dat,
  output logic             o_wb_ack,
  input  wire logic        i_timebase_tick,
  input  wire logic        i_timer0_match,
  input  wire logic        i_peripheral_interrupt_in,
  input  wire logic        i_spi_miso,
  output logic             o_spi_sck,
  output logic             o_spi_mosi,
  output logic             o_internal_slave_select_n,
  output logic             o_uart_module_enable,
  output logic             o_peripheral_clock_out,
  output logic      [2:0]  o_remap_select
);

  serial_ctrl_type ctrl_q, ctrl_d;
  pin_remap_type   remap_q, remap_d;
  logic [1:0]      link_q, link_d;
  logic            err_q, err_d;
  logic            ack_q, ack_d;
  logic [31:0]     rdat_q, rdat_d;
  logic            req, wr0, start;

  spi_state_type   st_q, st_d;
  logic [5:0]      div_q, div_d;
  logic [4:0]      edge_q, edge_d;
  logic [7:0]      tx_q, tx_d, rx_q, rx_d;
  logic            sck_q, sck_d, mosi_q, mosi_d, tick;
  logic [5:0]      half;

  logic [2:0]      pck_cnt_q, pck_cnt_d;
  logic            pck_half_q, pck_half_d, pck_q, pck_d, pck_pulse;

  logic            ssel_n_q, ssel_n_d, uen_q, uen_d;

  logic            mode_bad;

  assign req      = i_wb_cyc && i_wb_stb && !ack_q;
  assign wr0      = req && i_wb_we && i_wb_sel[0];
  assign mode_bad = ctrl_q.spi_mode_select > MODE_TIMER0;
  assign start    = wr0 && (i_wb_adr == OFS_SPI_DATA) && st_q == ST_IDLE && ctrl_q.serial_module_enable;

  // Register file and bus answer
  always_comb begin
    ctrl_d  = ctrl_q;
    remap_d = remap_q;
    link_d  = link_q;
    err_d   = err_q;
    ack_d   = req;
    rdat_d  = rdat_q;
    if (wr0) begin
      case (i_wb_adr)
        OFS_SERIAL_CTRL0: ctrl_d = serial_ctrl_type'(i_wb_dat[7:0]);
        OFS_PIN_REMAP0:   remap_d = pin_remap_type'(i_wb_dat[2:0]);
        OFS_LINK_CTRL:    link_d = i_wb_dat[1:0];
        OFS_STATUS:       if (i_wb_dat[ST_ERR_BIT]) err_d = 1'b0;
        default:          ;
      endcase
    end
    // Refused start on a reserved mode code sets the error flag; set wins
    if (wr0 && i_wb_adr == OFS_SPI_DATA && ctrl_q.serial_module_enable && mode_bad) begin
      err_d = 1'b1;
    end
    if (req && !i_wb_we) begin
      rdat_d = 32'h0;
      case (i_wb_adr)
        OFS_SERIAL_CTRL0: rdat_d[7:0] = ctrl_q;
        OFS_PIN_REMAP0:   rdat_d[2:0] = remap_q;
        OFS_SPI_DATA:     rdat_d[7:0] = rx_q;
        OFS_LINK_CTRL:    rdat_d[1:0] = link_q;
        OFS_STATUS: begin
          rdat_d[ST_BUSY_BIT] = (st_q == ST_XFER);
          rdat_d[ST_ERR_BIT]  = err_q;
          rdat_d[ST_INT_BIT]  = remap_q.remap_select_low & i_peripheral_interrupt_in;
          rdat_d[ST_SCK_BIT]  = sck_q;
        end
        default:          rdat_d = 32'h0;
      endcase
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      ctrl_q  <= serial_ctrl_type'(SERIAL_CTRL0_RESET);
      remap_q <= pin_remap_type'(PIN_REMAP0_RESET);
      link_q  <= LINK_CTRL_RESET;
      err_q   <= 1'b0;
      ack_q   <= 1'b0;
      rdat_q  <= 32'h0;
    end else if (i_clk_en) begin
      ctrl_q  <= ctrl_d;
      remap_q <= remap_d;
      link_q  <= link_d;
      err_q   <= err_d;
      ack_q   <= ack_d;
      rdat_q  <= rdat_d;
    end
  end

  // SPI clock source selection
  always_comb begin
    case (ctrl_q.spi_mode_select)
      MODE_DIV16: half = HALF_DIV16;
      MODE_DIV64: half = HALF_DIV64;
      default:    half = HALF_DIV4;
    endcase
    case (ctrl_q.spi_mode_select)
      MODE_DIV4, MODE_DIV16, MODE_DIV64: tick = (div_q == half - 6'h01);
      MODE_TIMEBASE:                     tick = i_timebase_tick;
      MODE_TIMER0:                       tick = i_timer0_match;
      default:                           tick = 1'b0;
    endcase
  end

  // SPI master engine, mode 0, MSB first
  always_comb begin
    st_d   = st_q;
    div_d  = div_q;
    edge_d = edge_q;
    tx_d   = tx_q;
    rx_d   = rx_q;
    sck_d  = sck_q;
    mosi_d = mosi_q;
    case (st_q)
      ST_IDLE: begin
        div_d = 6'h00;
        sck_d = 1'b0;
        if (start && !mode_bad) begin
          st_d   = ST_XFER;
          tx_d   = i_wb_dat[7:0];
          mosi_d = i_wb_dat[7];
          edge_d = 5'h00;
        end
      end
      ST_XFER: begin
        div_d = tick ? 6'h00 : div_q + 6'h01;
        if (!ctrl_q.serial_module_enable) begin
          st_d  = ST_IDLE;
          sck_d = 1'b0;
        end else if (tick) begin
          sck_d  = !sck_q;
          edge_d = edge_q + 5'h01;
          if (!sck_q) begin
            rx_d = {rx_q[6:0], i_spi_miso};
          end else if (edge_q == EDGES_LAST) begin
            st_d = ST_IDLE;
          end else begin
            tx_d   = {tx_q[6:0], 1'b0};
            mosi_d = tx_q[6];
          end
        end
      end
      default: st_d = ST_IDLE;
    endcase
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      st_q   <= ST_IDLE;
      div_q  <= 6'h00;
      edge_q <= 5'h00;
      tx_q   <= 8'h00;
      rx_q   <= 8'h00;
      sck_q  <= 1'b0;
      mosi_q <= 1'b0;
    end else if (i_clk_en) begin
      st_q   <= st_d;
      div_q  <= div_d;
      edge_q <= edge_d;
      tx_q   <= tx_d;
      rx_q   <= rx_d;
      sck_q  <= sck_d;
      mosi_q <= mosi_d;
    end
  end

  // Peripheral clock out as a clock-enable strobe stream at the chosen rate
  always_comb begin
    pck_cnt_d  = pck_cnt_q + 3'h1;
    pck_half_d = pck_half_q ^ i_timer0_match;
    case (ctrl_q.clock_out_rate_select)
      PCK_SYS:  pck_pulse = 1'b1;
      PCK_DIV4: pck_pulse = (pck_cnt_q[1:0] == PCK_LIM4[1:0]);
      PCK_DIV8: pck_pulse = (pck_cnt_q == PCK_LIM8);
      default:  pck_pulse = i_timer0_match && pck_half_q;
    endcase
    pck_d = ctrl_q.clock_out_enable && pck_pulse;
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      pck_cnt_q  <= 3'h0;
      pck_half_q <= 1'b0;
      pck_q      <= 1'b0;
    end else if (i_clk_en) begin
      pck_cnt_q  <= pck_cnt_d;
      pck_half_q <= pck_half_d;
      pck_q      <= pck_d;
    end
  end

  // Link control; UART enable is held off while the slave select is high
  always_comb begin
    ssel_n_d = link_q[0];
    uen_d    = link_q[1] && !link_q[0];
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      ssel_n_q <= 1'b1;
      uen_q    <= 1'b0;
    end else if (i_clk_en) begin
      ssel_n_q <= ssel_n_d;
      uen_q    <= uen_d;
    end
  end

  assign o_wb_dat                  = rdat_q;
  assign o_wb_ack                  = ack_q;
  assign o_spi_sck                 = sck_q;
  assign o_spi_mosi                = mosi_q;
  assign o_internal_slave_select_n = ssel_n_q;
  assign o_uart_module_enable      = uen_q;
  assign o_peripheral_clock_out    = pck_q;
  assign o_remap_select            = remap_q;

  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_sys_rst);

  ack_single_a: assert property (o_wb_ack |=> !o_wb_ack)
    else $error("ack held longer than one cycle");
  ack_answer_a: assert property ((req && i_clk_en) |=> o_wb_ack)
    else $error("bus request not answered in one cycle");
  remap_write_a: assert property ((wr0 && i_clk_en && i_wb_adr == OFS_PIN_REMAP0)
    |=> o_remap_select == $past(i_wb_dat[2:0]))
    else $error("remap write not reflected on outputs");
  div4_toggle_a: assert property ((st_q == ST_XFER && ctrl_q.spi_mode_select == MODE_DIV4
    && ctrl_q.serial_module_enable && div_q == 6'h01 && i_clk_en) |=> o_spi_sck != $past(o_spi_sck))
    else $error("divide-by-4 SPI clock missed its edge");
  div_steady_a: assert property ((st_q == ST_XFER && ctrl_q.spi_mode_select == MODE_DIV64
    && ctrl_q.serial_module_enable && div_q < 6'h1f) |=> $stable(o_spi_sck))
    else $error("divide-by-64 SPI clock toggled early");
  tb_toggle_a: assert property ((st_q == ST_XFER && ctrl_q.spi_mode_select == MODE_TIMEBASE
    && ctrl_q.serial_module_enable && i_timebase_tick && i_clk_en) |=> $changed(o_spi_sck))
    else $error("timebase tick did not move SPI clock");
  bad_mode_a: assert property ((wr0 && i_clk_en && i_wb_adr == OFS_SPI_DATA && mode_bad
    && ctrl_q.serial_module_enable) |=> err_q && st_q == ST_IDLE)
    else $error("reserved mode start not refused");
  pck_sys_a: assert property ((i_clk_en && ctrl_q.clock_out_enable
    && ctrl_q.clock_out_rate_select == PCK_SYS) |=> o_peripheral_clock_out)
    else $error("clock out missing at system rate");
  pck_off_a: assert property ((i_clk_en && !ctrl_q.clock_out_enable) |=> !o_peripheral_clock_out)
    else $error("clock out active while disabled");
  no_start_a: assert property ((st_q == ST_IDLE && !ctrl_q.serial_module_enable) |=> st_q == ST_IDLE)
    else $error("transfer began while module disabled");
  uart_order_a: assert property (o_uart_module_enable |-> !o_internal_slave_select_n)
    else $error("UART enabled with slave select high");
  t0_toggle_a: assert property ((st_q == ST_XFER && ctrl_q.spi_mode_select == MODE_TIMER0
    && ctrl_q.serial_module_enable && i_timer0_match && i_clk_en) |=> $changed(o_spi_sck))
    else $error("timer match did not move SPI clock");
  pck_div4_a: assert property ((i_clk_en && ctrl_q.clock_out_enable
    && ctrl_q.clock_out_rate_select == PCK_DIV4 && pck_cnt_q[1:0] != PCK_LIM4[1:0]) |=> !o_peripheral_clock_out)
    else $error("divide-by-4 clock out pulsed early");
  pck_div8_a: assert property ((i_clk_en && ctrl_q.clock_out_enable
    && ctrl_q.clock_out_rate_select == PCK_DIV8 && pck_cnt_q != PCK_LIM8) |=> !o_peripheral_clock_out)
    else $error("divide-by-8 clock out pulsed early");
  pck_t0_a: assert property ((i_clk_en && ctrl_q.clock_out_enable
    && ctrl_q.clock_out_rate_select == PCK_TIMER0 && i_timer0_match && pck_half_q) |=> o_peripheral_clock_out)
    else $error("timer clock out missed its pulse");
  abort_idle_a: assert property ((st_q == ST_XFER && !ctrl_q.serial_module_enable && i_clk_en)
    |=> st_q == ST_IDLE && !o_spi_sck)
    else $error("disabled transfer not stopped");

  xfer_done_c: cover property (st_q == ST_XFER ##1 st_q == ST_IDLE);
  pck_t0_c: cover property (ctrl_q.clock_out_rate_select == PCK_TIMER0 && o_peripheral_clock_out);
  bad_mode_c: cover property ($rose(err_q));
  pck_div8_c: cover property (ctrl_q.clock_out_rate_select == PCK_DIV8 && o_peripheral_clock_out);
  abort_c: cover property (st_q == ST_XFER && !ctrl_q.serial_module_enable);

endmodule

// [bench/uart_spi_slave_model.sv]
`timescale 1ns/1ps
module uart_spi_slave_model (
  input  wire logic       i_clk,
  input  wire logic       i_sck,
  input  wire logic       i_mosi,
  input  wire logic       i_ssel_n,
  input  wire logic       i_uart_en,
  input  wire logic [7:0] i_tx,
  output logic            o_miso,
  output logic      [7:0] o_rx,
  output logic            o_order_err
);
  int   idx = 0;
  logic junk = 1'b0;
  initial o_rx = 8'h00;
  initial o_order_err = 1'b0;
  // Deselected line shows no stale bit
  always @(posedge i_clk) junk <= ~junk;
  assign o_miso = i_ssel_n ? junk : i_tx[7 - idx];
  always @(posedge i_sck) if (!i_ssel_n) o_rx <= {o_rx[6:0], i_mosi};
  always @(negedge i_sck) if (!i_ssel_n) idx <= (idx + 1) % 8;
  // Enable while still deselected is a power-up fault
  always @(posedge i_uart_en) if (i_ssel_n) o_order_err <= 1'b1;
endmodule

// [bench/test_spi_uart_bridge.sv]
`timescale 1ns/1ps
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin error_cnt++; \
  $display("[FAIL] %s exp %h got %h", nm, e, g); end end
module test_spi_uart_bridge;
  import spi_bridge_pkg::*;
  logic        clk = 1'b0, rst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic        tb_tick = 1'b0, t0m = 1'b0, peripheral_interrupt_in = 1'b0, sck_d = 1'b0;
  logic        ack, miso, sck, mosi, ssel_n, uen, peripheral_clock_out, ord_err;
  logic [2:0]  remap;
  logic [3:0]  sel = 4'h0;
  logic [7:0]  adr = 8'h00, slv_tx = 8'h00, slv_rx;
  logic [15:0] seed = 16'h7e2c;
  logic [31:0] wdat = 32'h0, rdat, q;
  int          error_cnt = 0, cmp_count = 0, cyc_no = 0, pck_cnt = 0, last_rise = 0, sck_per = 0;
  int          per_tab[5] = '{4, 16, 64, 6, 6};
  int          rst_tab[5] = '{0, 0, 0, 1, 0};
  logic [7:0]  exp_q[$];

  always #20 clk = ~clk;

  spi_uart_bridge spi_uart_bridge_i (
    .i_sys_clk(clk), .i_sys_rst(rst), .i_clk_en(1'b1), .i_wb_cyc(cyc), .i_wb_stb(stb),
    .i_wb_we(we), .i_wb_adr(adr), .i_wb_dat(wdat), .i_wb_sel(sel), .o_wb_dat(rdat),
    .o_wb_ack(ack), .i_timebase_tick(tb_tick), .i_timer0_match(t0m),
    .i_peripheral_interrupt_in(peripheral_interrupt_in), .i_spi_miso(miso), .o_spi_sck(sck), .o_spi_mosi(mosi),
    .o_internal_slave_select_n(ssel_n), .o_uart_module_enable(uen),
    .o_peripheral_clock_out(peripheral_clock_out), .o_remap_select(remap));

  uart_spi_slave_model uart_spi_slave_model_i (
    .i_clk(clk), .i_sck(sck), .i_mosi(mosi), .i_ssel_n(ssel_n), .i_uart_en(uen),
    .i_tx(slv_tx), .o_miso(miso), .o_rx(slv_rx), .o_order_err(ord_err));

  // Settled sampling of strobes and clock edges, plus hang guard
  always @(negedge clk) begin
    cyc_no++;
    pck_cnt += int'(peripheral_clock_out === 1'b1);
    if (sck === 1'b1 && sck_d === 1'b0) begin
      sck_per = cyc_no - last_rise;
      last_rise = cyc_no;
    end
    sck_d = sck;
    if (cyc_no > 40000) begin
      error_cnt++;
      summarize();
    end
  end

  always @(posedge clk) begin
    tb_tick <= (cyc_no % 3 == 0);
    t0m <= (cyc_no % 3 == 0);
  end

  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  task automatic summarize();
    $display("counts: %0d compares, %0d mismatches", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // Ack and read data are taken at the rising edge that samples ack high
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= 4'hf;
    @(posedge clk);
    while (ack !== 1'b1) @(posedge clk);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk);
  endtask

  // Enable goes low first, fields change while it is low, then enable
  task automatic cfg(input logic [2:0] m, input logic [2:0] pf);
    wb(1'b0, OFS_SERIAL_CTRL0, 32'h0);
    wb(1'b1, OFS_SERIAL_CTRL0, {24'h0, q[7:2], 2'b00});
    wb(1'b1, OFS_SERIAL_CTRL0, {24'h0, m, pf, 2'b00});
    wb(1'b1, OFS_SERIAL_CTRL0, {24'h0, m, pf, 2'b10});
  endtask

  task automatic pck_rate(input logic [2:0] pf, input int exp);
    cfg(MODE_DIV4, pf);
    repeat (12) @(posedge clk);
    pck_cnt = 0;
    repeat (48) @(posedge clk);
    `CHK("pck count", exp, pck_cnt)
  endtask

  task automatic xfer(input logic [2:0] m);
    logic [7:0] d;
    cfg(m, 3'b000);
    seed = lfsr(seed);
    d = seed[7:0];
    slv_tx = seed[15:8];
    exp_q.push_back(d);
    wb(1'b1, OFS_SPI_DATA, {24'h0, d});
    q = 32'h1;
    while (q[0] !== 1'b0) wb(1'b0, OFS_STATUS, 32'h0);
    `CHK("mosi byte", exp_q[0], slv_rx)
    void'(exp_q.pop_front());
    `CHK("sck period", per_tab[m], sck_per)
    wb(1'b0, OFS_SPI_DATA, 32'h0);
    `CHK("miso byte", slv_tx, q[7:0])
    $display("test transfer mode %0d done", m);
  endtask

  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < 5; i++) begin
      wb(1'b0, 8'(i * 4), 32'h0);
      `CHK("reset reg", rst_tab[i], q)
    end
    `CHK("reset select", 1'b1, ssel_n)
    $display("test reset done");
    peripheral_interrupt_in <= 1'b1;
    wb(1'b1, OFS_PIN_REMAP0, 32'h7);
    `CHK("remap pins", 3'h7, remap)
    wb(1'b0, OFS_STATUS, 32'h0);
    `CHK("interrupt line", 32'h4, q)
    wb(1'b1, OFS_PIN_REMAP0, 32'h3);
    wb(1'b0, OFS_PIN_REMAP0, 32'h0);
    `CHK("remap read", 32'h3, q)
    `CHK("remap pins", 3'h3, remap)
    $display("test remap done");
    wb(1'b1, OFS_LINK_CTRL, 32'h0);
    wb(1'b1, OFS_LINK_CTRL, 32'h2);
    `CHK("slave select", 1'b0, ssel_n)
    `CHK("uart enable", 1'b1, uen)
    `CHK("power order", 1'b0, ord_err)
    $display("test link done");
    pck_rate(3'b100, 48);
    pck_rate(3'b101, 12);
    pck_rate(3'b110, 6);
    pck_rate(3'b111, 8);
    pck_rate(3'b011, 0);
    $display("test clock out done");
    for (int m = 0; m < 5; m++) xfer(3'(m));
    for (int m = 5; m < 8; m++) begin
      cfg(3'(m), 3'b000);
      wb(1'b1, OFS_SPI_DATA, 32'h5a);
      wb(1'b0, OFS_STATUS, 32'h0);
      `CHK("reserved status", 32'h6, q)
      wb(1'b1, OFS_STATUS, 32'h2);
    end
    $display("test reserved done");
    cfg(MODE_DIV64, 3'b000);
    wb(1'b1, OFS_SPI_DATA, 32'h3c);
    wb(1'b1, OFS_SERIAL_CTRL0, {24'h0, MODE_DIV64, 5'h00});
    wb(1'b0, OFS_STATUS, 32'h0);
    `CHK("abort status", 32'h4, q)
    $display("test abort done");
    wb(1'b1, OFS_SERIAL_CTRL0, 32'h0);
    wb(1'b1, OFS_SPI_DATA, 32'ha5);
    wb(1'b0, OFS_STATUS, 32'h0);
    `CHK("disabled status", 32'h4, q)
    $display("test disabled done");
    summarize();
  end
endmodule
